// >>> kms_scanner.sv
`timescale 1ns/1ns
`include "kms_map.svh"

// Summary of operation
// R1: scan mode latches the accepted key's column pattern into column value.
// R2: bypass mode drives column pins straight from written column value.
// R3: column value is five active-low bits, 0x1F means all high.
// R4: row value holds six active-low row bits, 0x3F means all high.
// R5: an accepted key's row pattern is latched into row value.
// R6: bypass mode reads of row value return the live row pins.
// R7: size settings matter only with scan enabled; unused rows tied high.
// R8: row count field bits 5:3 sets scanned rows, at most six.
// R9: column count field bits 2:0 sets scanned columns, at most five.
// R10: scan order is five three-bit slots, each naming a column pin.
// R11: scan steps slots first to fifth, wrapping to the first after column count slots.
// R12: firmware loads counting pattern 0..4 for a sequential scan.
// R13: firmware rewrites scan order in its interrupt service routine.
// R14: low order register holds slot one, slot two, slot three low bits.
// R15: accepted key raises sticky key-detected interrupt flag, write-one clear.
// R16: selected column low, others high; any low row is a candidate.

module kms_scanner
  import kms_pkg::*;
#(
  parameter int DWELL_CYCLES = `KMS_DWELL_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire kms_apb_req_s apbReq,
  output kms_apb_rsp_s apbRsp,
  input wire logic [5:0] rowIn,
  output logic [4:0] colOut,
  output logic keyIrq
);

  localparam logic [15:0] DWELL_LAST = 16'(DWELL_CYCLES - 1);

  kms_regs_s r_reg;
  kms_regs_s r_next;

  // ========================================
  // helpers
  function automatic logic [2:0] clampCount(
    input logic [2:0] cnt,
    input logic [2:0] maxCnt
  );
    if (cnt == 3'h0 || cnt > maxCnt) begin
      return maxCnt;
    end
    return cnt;
  endfunction : clampCount

  function automatic logic [4:0] colPattern(input logic [2:0] num);
    logic [4:0] pat;
    pat = `KMS_ALL_COLS_HIGH;
    if (num < `KMS_MAX_COLS) begin
      pat[num] = 1'b0;
    end
    return pat;
  endfunction : colPattern

  logic [14:0] order;
  logic [2:0] rowCnt;
  logic [2:0] colCnt;
  logic [5:0] rowMask;
  logic [5:0] rowsScan;
  logic [2:0] slotNext;
  logic tick;
  logic keySeen;
  logic setup;
  logic access;
  logic wrEn;
  logic hit;
  logic mapped;
  logic [7:0] idx;
  logic [31:0] rdData;

  // ========================================
  // decode and derived values
  always_comb begin
    order = {r_reg.ordHi, r_reg.ordLo}; // [R10] [R14]
    rowCnt = clampCount(
      r_reg.size[`KMS_ROWSZ_MSB:`KMS_ROWSZ_LSB], `KMS_MAX_ROWS); // [R8]
    colCnt = clampCount(
      r_reg.size[`KMS_COLSZ_MSB:`KMS_COLSZ_LSB], `KMS_MAX_COLS); // [R9]
    for (int i = 0; i < `KMS_ROWS; i++) begin
      rowMask[i] = (3'(i) < rowCnt);
    end
    // rows beyond the count read as released
    rowsScan = r_reg.rowS2 | ~rowMask; // [R7] [R8]
    keySeen = (rowsScan != `KMS_ALL_ROWS_HIGH); // [R16]
    tick = (r_reg.dwell == DWELL_LAST);
    if (r_reg.slot + 3'h1 >= colCnt) begin
      slotNext = 3'h0; // [R11]
    end else begin
      slotNext = r_reg.slot + 3'h1; // [R11]
    end
    setup = apbReq.psel && !apbReq.penable;
    access = apbReq.psel && apbReq.penable;
    idx = apbReq.paddr[9:2];
    hit = (apbReq.paddr[1:0] == 2'h0) && mapped;
    wrEn = access && apbReq.pwrite && hit;
  end

  // ========================================
  // address decode
  always_comb begin
    mapped = 1'b0;
    unique case (idx)
      `KMS_IDX_COL,
      `KMS_IDX_ROW,
      `KMS_IDX_SIZE,
      `KMS_IDX_ORDL,
      `KMS_IDX_ORDH,
      `KMS_IDX_CTRL,
      `KMS_IDX_INTST,
      `KMS_IDX_INTMSK: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ========================================
  // read mux
  always_comb begin
    rdData = 32'h0000_0000;
    if (apbReq.paddr[1:0] == 2'h0) begin
      unique case (idx)
        `KMS_IDX_COL: begin
          rdData[4:0] = r_reg.colVal; // [R3]
        end
        `KMS_IDX_ROW: begin
          if (r_reg.hwEn) begin
            rdData[5:0] = r_reg.rowVal; // [R4] [R5]
          end else begin
            rdData[5:0] = r_reg.rowS2; // [R6]
          end
        end
        `KMS_IDX_SIZE: begin
          rdData[5:0] = r_reg.size;
        end
        `KMS_IDX_ORDL: begin
          rdData[7:0] = r_reg.ordLo;
        end
        `KMS_IDX_ORDH: begin
          rdData[6:0] = r_reg.ordHi;
        end
        `KMS_IDX_CTRL: begin
          rdData[`KMS_CTRL_HWEN] = r_reg.hwEn;
        end
        `KMS_IDX_INTST: begin
          rdData[`KMS_INT_KEY] = r_reg.intSt;
        end
        `KMS_IDX_INTMSK: begin
          rdData[`KMS_INT_KEY] = r_reg.intMask;
        end
        default: begin
          rdData = 32'h0000_0000;
        end
      endcase
    end
  end

  // ========================================
  // next state
  always_comb begin
    r_next = r_reg;
    r_next.rowS1 = rowIn;
    r_next.rowS2 = r_reg.rowS1;

    // register writes
    if (wrEn) begin
      unique case (idx)
        `KMS_IDX_COL: begin
          r_next.colVal = apbReq.pwdata[4:0]; // [R2]
        end
        `KMS_IDX_SIZE: begin
          r_next.size = apbReq.pwdata[5:0];
        end
        `KMS_IDX_ORDL: begin
          r_next.ordLo = apbReq.pwdata[7:0]; // [R14]
        end
        `KMS_IDX_ORDH: begin
          r_next.ordHi = apbReq.pwdata[6:0];
        end
        `KMS_IDX_CTRL: begin
          r_next.hwEn = apbReq.pwdata[`KMS_CTRL_HWEN];
        end
        `KMS_IDX_INTST: begin
          if (apbReq.pwdata[`KMS_INT_KEY]) begin
            r_next.intSt = 1'b0;
          end
        end
        `KMS_IDX_INTMSK: begin
          r_next.intMask = apbReq.pwdata[`KMS_INT_KEY];
        end
        default: begin
          r_next.intMask = r_reg.intMask;
        end
      endcase
    end

    // read data and error captured in the setup cycle
    if (setup) begin
      if (apbReq.pwrite) begin
        r_next.prdata = 32'h0000_0000;
      end else begin
        r_next.prdata = rdData;
      end
      r_next.errFlag = !hit;
    end

    // dwell timer per column slot
    if (r_reg.st == KMS_IDLE || tick) begin
      r_next.dwell = 16'h0000;
    end else begin
      r_next.dwell = r_reg.dwell + 16'h0001;
    end

    // scanner
    unique case (r_reg.st)
      KMS_IDLE: begin
        if (r_reg.hwEn) begin
          r_next.st = KMS_SCAN;
          r_next.slot = 3'h0;
        end
      end
      KMS_SCAN: begin
        if (!r_reg.hwEn) begin
          r_next.st = KMS_IDLE;
        end else if (tick) begin
          if (keySeen) begin
            r_next.candRow = rowsScan; // [R16]
            r_next.st = KMS_CONFIRM;
          end else begin
            r_next.slot = slotNext; // [R11]
          end
        end
      end
      KMS_CONFIRM: begin
        if (!r_reg.hwEn) begin
          r_next.st = KMS_IDLE;
        end else if (tick) begin
          if (rowsScan == r_reg.candRow) begin
            r_next.colVal = r_reg.colDrv; // [R1]
            r_next.rowVal = r_reg.candRow; // [R5]
            r_next.intSt = 1'b1; // [R15]
            r_next.st = KMS_HOLD;
          end else begin
            r_next.st = KMS_SCAN;
          end
        end
      end
      KMS_HOLD: begin
        if (!r_reg.hwEn) begin
          r_next.st = KMS_IDLE;
        end else if (tick && !keySeen) begin
          r_next.slot = slotNext; // [R11]
          r_next.st = KMS_SCAN;
        end
      end
      default: r_next.st = KMS_IDLE;
    endcase

    // column drive
    if (r_next.st == KMS_IDLE) begin
      r_next.colDrv = r_next.colVal; // [R2] [R7]
    end else begin
      r_next.colDrv = colPattern(order[3 * r_next.slot +: 3]); // [R11] [R16]
    end
  end

  // ========================================
  // state register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r_reg.st <= KMS_IDLE;
      r_reg.colVal <= `KMS_RST_COL;
      r_reg.rowVal <= `KMS_RST_ROW;
      r_reg.size <= `KMS_RST_SIZE;
      r_reg.ordLo <= `KMS_RST_ORDL;
      r_reg.ordHi <= `KMS_RST_ORDH;
      r_reg.hwEn <= 1'b0;
      r_reg.intSt <= 1'b0;
      r_reg.intMask <= 1'b0;
      r_reg.slot <= 3'h0;
      r_reg.dwell <= 16'h0000;
      r_reg.candRow <= `KMS_ALL_ROWS_HIGH;
      r_reg.colDrv <= `KMS_ALL_COLS_HIGH;
      r_reg.rowS1 <= `KMS_ALL_ROWS_HIGH;
      r_reg.rowS2 <= `KMS_ALL_ROWS_HIGH;
      r_reg.prdata <= 32'h0000_0000;
      r_reg.errFlag <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ========================================
  // outputs
  assign colOut = r_reg.colDrv;
  assign keyIrq = r_reg.intSt && r_reg.intMask; // [R15]
  assign apbRsp.prdata = r_reg.prdata;
  assign apbRsp.pready = access;
  assign apbRsp.pslverr = access && r_reg.errFlag;

endmodule : kms_scanner

// >>> kms_map.svh
`ifndef KMS_MAP_SVH
`define KMS_MAP_SVH

// ========================================
// register indexes (byte address = 4 * index)
`define KMS_IDX_COL 8'hd1
`define KMS_IDX_ROW 8'hd2
`define KMS_IDX_SIZE 8'hd5
`define KMS_IDX_ORDL 8'hd6
`define KMS_IDX_ORDH 8'hd7
`define KMS_IDX_CTRL 8'hd8
`define KMS_IDX_INTST 8'hd9
`define KMS_IDX_INTMSK 8'hda

// ========================================
// reset values
`define KMS_RST_COL 5'h1f
`define KMS_RST_ROW 6'h3f
`define KMS_RST_SIZE 6'h00
`define KMS_RST_ORDL 8'h00
`define KMS_RST_ORDH 7'h00

// ========================================
// field layout and limits
`define KMS_COLS 5
`define KMS_ROWS 6
`define KMS_ALL_COLS_HIGH 5'h1f
`define KMS_ALL_ROWS_HIGH 6'h3f
`define KMS_MAX_ROWS 3'h6
`define KMS_MAX_COLS 3'h5
`define KMS_ROWSZ_MSB 5
`define KMS_ROWSZ_LSB 3
`define KMS_COLSZ_MSB 2
`define KMS_COLSZ_LSB 0
`define KMS_CTRL_HWEN 0
`define KMS_INT_KEY 0

// ========================================
// timing
`define KMS_CLK_NS 40
`define KMS_DWELL_NS 1000000
`define KMS_DWELL_CYCLES (`KMS_DWELL_NS / `KMS_CLK_NS)

`endif

// >>> kms_pkg.sv
package kms_pkg;

  // ========================================
  // scanner states
  typedef enum logic [3:0] {
    KMS_IDLE = 4'b0001,
    KMS_SCAN = 4'b0010,
    KMS_CONFIRM = 4'b0100,
    KMS_HOLD = 4'b1000
  } kms_state_e;

  // ========================================
  // apb carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [9:0] paddr;
    logic [31:0] pwdata;
  } kms_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } kms_apb_rsp_s;

  // ========================================
  // whole block state
  typedef struct packed {
    kms_state_e st;
    logic [4:0] colVal;
    logic [5:0] rowVal;
    logic [5:0] size;
    logic [7:0] ordLo;
    logic [6:0] ordHi;
    logic hwEn;
    logic intSt;
    logic intMask;
    logic [2:0] slot;
    logic [15:0] dwell;
    logic [5:0] candRow;
    logic [4:0] colDrv;
    logic [5:0] rowS1;
    logic [5:0] rowS2;
    logic [31:0] prdata;
    logic errFlag;
  } kms_regs_s;

endpackage : kms_pkg

// >>> kms_scanner_props.sv
`timescale 1ns/1ns
// ========================================
// port checker
module kms_scanner_props
  import kms_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire kms_apb_req_s apbReq,
  input wire kms_apb_rsp_s apbRsp,
  input wire logic [5:0] rowIn,
  input wire logic [4:0] colOut,
  input wire logic keyIrq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  a_reset_idle: assert property ($fell(reset) |-> colOut == 5'h1f && !keyIrq)
    else $error("outputs not idle after reset");
  a_ready_follow: assert property (apbRsp.pready == (apbReq.psel && apbReq.penable))
    else $error("pready not access phase");
  a_err_access: assert property (apbRsp.pslverr |-> apbReq.psel && apbReq.penable)
    else $error("pslverr outside access");
  a_err_misalign: assert property (apbReq.psel && apbReq.penable
    && apbReq.paddr[1:0] != 2'h0 |-> apbRsp.pslverr)
    else $error("misaligned access not refused");
  a_err_rzero: assert property (apbRsp.pslverr && !apbReq.pwrite
    |-> apbRsp.prdata == 32'h0000_0000)
    else $error("refused read not zero");
  a_upper_zero: assert property (apbRsp.pready && !apbReq.pwrite
    |-> apbRsp.prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_rdata_stands: assert property (apbRsp.pready |=> $stable(apbRsp.prdata))
    else $error("read data moved");
  a_irq_clear_cause: assert property ($fell(keyIrq)
    |-> $past(apbReq.psel && apbReq.penable && apbReq.pwrite))
    else $error("irq fell without write");
  c_irq: cover property ($rose(keyIrq));
  c_err: cover property (apbRsp.pslverr);
  c_col4: cover property (colOut == 5'h0f);
endmodule : kms_scanner_props

bind kms_scanner kms_scanner_props kms_scanner_props_i (.sys_clk(sys_clk),
  .reset(reset), .apbReq(apbReq), .apbRsp(apbRsp), .rowIn(rowIn),
  .colOut(colOut), .keyIrq(keyIrq));

// >>> kms_keypad.sv
`timescale 1ns/1ns
// ========================================
// one switch of a pulled-up matrix
module kms_keypad (
  input wire logic [4:0] colOut,
  input wire logic [2:0] keyRow,
  input wire logic [2:0] keyCol,
  input wire logic pressed,
  output logic [5:0] rowIn
);
  always_comb begin
    rowIn = 6'h3f;
    if (pressed && !colOut[keyCol]) begin
      rowIn[keyRow] = 1'b0;
    end
  end
endmodule : kms_keypad

// >>> keypad_matrix_scanner_tb.sv
`timescale 1ns/1ns
`include "kms_map.svh"
module keypad_matrix_scanner_tb;
  import kms_pkg::*;
  logic sys_clk = 0;
  logic reset = 1;
  logic pressed = 0;
  logic keyIrq;
  logic [2:0] keyRow = 0;
  logic [2:0] keyCol = 0;
  logic [5:0] rowIn;
  logic [4:0] colOut;
  kms_apb_req_s req = '0;
  kms_apb_rsp_s rsp;
  logic [31:0] rdv;
  logic rde;
  int errors = 0;
  int checksDone = 0;
  int cycles = 0;
  localparam logic [9:0] A_COL = {`KMS_IDX_COL, 2'b00};
  localparam logic [9:0] A_ROW = {`KMS_IDX_ROW, 2'b00};
  localparam logic [9:0] A_SIZE = {`KMS_IDX_SIZE, 2'b00};
  localparam logic [9:0] A_ORDL = {`KMS_IDX_ORDL, 2'b00};
  localparam logic [9:0] A_ORDH = {`KMS_IDX_ORDH, 2'b00};
  localparam logic [9:0] A_CTRL = {`KMS_IDX_CTRL, 2'b00};
  localparam logic [9:0] A_INT = {`KMS_IDX_INTST, 2'b00};
  localparam logic [9:0] A_MSK = {`KMS_IDX_INTMSK, 2'b00};
  kms_scanner #(.DWELL_CYCLES(8)) kms_scanner_i (.sys_clk(sys_clk),
    .reset(reset), .apbReq(req), .apbRsp(rsp), .rowIn(rowIn),
    .colOut(colOut), .keyIrq(keyIrq));
  kms_keypad kms_keypad_i (.colOut(colOut), .keyRow(keyRow),
    .keyCol(keyCol), .pressed(pressed), .rowIn(rowIn));
  initial forever #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ========================================
  // helpers
  task automatic chk(input logic [31:0] got, exp, input string what);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    @(posedge sys_clk);
    while (rsp.pready !== 1'b1) @(posedge sys_clk);
    rdv = rsp.prdata;
    rde = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic press(input logic [2:0] r, c, input logic p);
    @(posedge sys_clk);
    keyRow <= r;
    keyCol <= c;
    pressed <= p;
  endtask : press
  task automatic wait_irq;
    for (int n = 0; n < 400 && keyIrq !== 1'b1; n++) @(posedge sys_clk);
  endtask : wait_irq
  // ========================================
  // scenarios
  task automatic t_reset;
    apb(0, A_COL, 0); chk(rdv, 32'h0000_001f, "col");
    apb(0, A_ROW, 0); chk(rdv, 32'h0000_003f, "row");
    apb(0, A_SIZE, 0); chk(rdv, 32'h0000_0000, "size");
    apb(0, A_ORDL, 0); chk(rdv, 32'h0000_0000, "ordl");
  endtask : t_reset
  task automatic t_bypass;
    apb(1, A_COL, 32'h0000_001e);
    repeat (2) @(posedge sys_clk);
    chk(colOut, 5'h1e, "colOut");
    press(0, 0, 1);
    repeat (3) @(posedge sys_clk);
    apb(0, A_ROW, 0); chk(rdv, 32'h0000_003e, "live row");
    apb(1, A_ROW, 0);
    apb(0, A_ROW, 0); chk(rdv, 32'h0000_003e, "row ro");
    press(0, 0, 0);
    apb(1, A_COL, 32'h0000_001f);
    apb(0, A_COL + 10'h001, 0); chk(rdv, 32'h0, "misalign");
    chk(rde, 1'b1, "misalign err");
  endtask : t_bypass
  task automatic t_scan_full;
    apb(1, A_SIZE, 32'h0000_0035);
    apb(1, A_ORDL, 32'h0000_0088);
    apb(1, A_ORDH, 32'h0000_0046);
    apb(1, A_MSK, 1);
    apb(1, A_CTRL, 1);
    press(3, 4, 1);
    wait_irq();
    chk(keyIrq, 1'b1, "irq");
    chk(colOut, 5'h0f, "held col");
    apb(0, A_COL, 0); chk(rdv, 32'h0000_000f, "key col");
    apb(0, A_ROW, 0); chk(rdv, 32'h0000_0037, "key row");
    apb(0, A_INT, 0); chk(rdv, 32'h0000_0001, "status");
    press(3, 4, 0);
    apb(1, A_INT, 1);
    repeat (2) @(posedge sys_clk);
    chk(keyIrq, 1'b0, "irq clr");
  endtask : t_scan_full
  task automatic t_scan_small;
    apb(1, A_MSK, 0);
    apb(1, A_SIZE, 32'h0000_0012);
    apb(1, A_ORDL, 32'h0000_000b);
    press(3, 3, 1);
    repeat (120) @(posedge sys_clk);
    apb(0, A_INT, 0); chk(rdv, 32'h0, "row beyond count");
    press(0, 0, 1);
    repeat (120) @(posedge sys_clk);
    apb(0, A_INT, 0); chk(rdv, 32'h0, "col not in order");
    press(1, 1, 1);
    repeat (120) @(posedge sys_clk);
    chk(keyIrq, 1'b0, "masked irq");
    apb(0, A_COL, 0); chk(rdv, 32'h0000_001d, "col1");
    apb(0, A_ROW, 0); chk(rdv, 32'h0000_003d, "row1");
    apb(1, A_MSK, 1);
    repeat (2) @(posedge sys_clk);
    chk(keyIrq, 1'b1, "unmasked irq");
  endtask : t_scan_small
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_bypass();
    t_scan_full();
    t_scan_small();
    tally_and_finish();
  end
endmodule : keypad_matrix_scanner_tb
